// ===== common/sdcc_pkg.sv
// Purpose: Shared constants, bus carriers and helpers for the sinc decoder channel control block.
// Assumes: AXI4-Lite with 8-bit byte addresses and 32-bit data, one word per register.
// Notes:   The control register keeps its printed index; its byte address is four times it.
package sdcc_pkg;

   // Bus geometry and responses.
   localparam int unsigned AXI_ADDR_W = 8;
   localparam int unsigned AXI_DATA_W = 32;
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

   // Register map.
   localparam logic [5:0] CTRL_INDEX   = 6'h11;
   localparam logic [7:0] ADDR_CTRL    = {CTRL_INDEX, 2'h0};
   localparam logic [7:0] ADDR_SAMPLE4 = 8'h48;
   localparam logic [7:0] ADDR_SAMPLE5 = 8'h4C;
   localparam logic [7:0] ADDR_STATUS  = 8'h50;
   localparam logic [7:0] ADDR_MASK    = 8'h54;

   // Control register field positions and reset value.
   localparam int unsigned BIT_FLAG4   = 4;
   localparam int unsigned BIT_FLAG5   = 5;
   localparam int unsigned OSR_LSB     = 6;
   localparam int unsigned BIT_DEC0_EN = 8;
   localparam int unsigned BIT_IRQ_EN  = 14;
   localparam int unsigned BIT_ROUTE   = 15;
   localparam logic [15:0] CTRL_RESET  = 16'h0000;

   // Interrupt status and mask layout.
   localparam int unsigned IRQ_W       = 3;
   localparam int unsigned IRQ_CH4     = 0;
   localparam int unsigned IRQ_CH5     = 1;
   localparam int unsigned IRQ_SLIP    = 2;
   localparam logic [2:0]  IRQ_RESET   = 3'h0;

   // Filter widths: 256 cubed needs 25 bits of unsigned headroom.
   localparam int unsigned FILT_W   = 25;
   localparam int unsigned SAMPLE_W = 16;

   // Master side of the register bus.
   typedef struct packed {
      logic                  awvalid;
      logic [AXI_ADDR_W-1:0] awaddr;
      logic [2:0]            awprot;
      logic                  wvalid;
      logic [AXI_DATA_W-1:0] wdata;
      logic [3:0]            wstrb;
      logic                  bready;
      logic                  arvalid;
      logic [AXI_ADDR_W-1:0] araddr;
      logic [2:0]            arprot;
      logic                  rready;
   } sdcc_axil_req_t;

   // Answers of the slave.
   typedef struct packed {
      logic                  awready;
      logic                  wready;
      logic                  bvalid;
      logic [1:0]            bresp;
      logic                  arready;
      logic                  rvalid;
      logic [AXI_DATA_W-1:0] rdata;
      logic [1:0]            rresp;
   } sdcc_axil_rsp_t;

   // Last pair index of one decimation period for a ratio code.
   function automatic logic [7:0] osr_last(input logic [1:0] code);
      unique case (code)
         2'h0: osr_last = 8'h1F;
         2'h1: osr_last = 8'h3F;
         2'h2: osr_last = 8'h7F;
         2'h3: osr_last = 8'hFF;
      endcase
   endfunction : osr_last

   // Scales the cubic sum so that full scale sits in the top of 16 bits.
   function automatic logic [SAMPLE_W-1:0] osr_scale(input logic [FILT_W-1:0] acc,
                                                     input logic [1:0]        code);
      unique case (code)
         2'h0: osr_scale = acc[15:0];
         2'h1: osr_scale = acc[18:3];
         2'h2: osr_scale = acc[21:6];
         2'h3: osr_scale = acc[24:9];
      endcase
   endfunction : osr_scale

endpackage : sdcc_pkg

// ===== logic/sdcc_sinc3.sv
// Purpose: Cubic sinc decimator for one bitstream channel.
// Assumes: decim pulses one cycle after the last input bit of a period.
// Notes:   Integrators wrap on purpose; the comb stages undo the wrap exactly.
`timescale 1ns/10ps
module sdcc_sinc3 (
   // Clock and reset.
   input  wire logic                           aclk,
   input  wire logic                           aresetn,
   // Control.
   input  wire logic                           enable,
   input  wire logic [1:0]                     osr_code,
   // Bitstream in.
   input  wire logic                           in_valid,
   input  wire logic                           in_bit,
   input  wire logic                           decim,
   // Samples out.
   output logic                                out_valid,
   output logic [sdcc_pkg::SAMPLE_W-1:0]       out_sample
);
   typedef struct packed {
      logic [sdcc_pkg::FILT_W-1:0] i1;
      logic [sdcc_pkg::FILT_W-1:0] i2;
      logic [sdcc_pkg::FILT_W-1:0] i3;
      logic [sdcc_pkg::FILT_W-1:0] d1;
      logic [sdcc_pkg::FILT_W-1:0] d2;
      logic [sdcc_pkg::FILT_W-1:0] d3;
      logic                        valid;
      logic [sdcc_pkg::SAMPLE_W-1:0] sample;
   } sdcc_sinc_state_t;

   sdcc_sinc_state_t s;
   sdcc_sinc_state_t next_s;
   logic [sdcc_pkg::FILT_W-1:0] c1;
   logic [sdcc_pkg::FILT_W-1:0] c2;
   logic [sdcc_pkg::FILT_W-1:0] c3;

   // Integrate each bit, comb once per period; disable clears all.
   always_comb begin
      next_s       = s;
      next_s.valid = 1'b0;
      c1 = s.i3 - s.d1;
      c2 = c1 - s.d2;
      c3 = c2 - s.d3;
      if (in_valid) begin
         next_s.i1 = s.i1 + {{(sdcc_pkg::FILT_W-1){1'b0}}, in_bit};
         next_s.i2 = s.i2 + s.i1;
         next_s.i3 = s.i3 + s.i2;
      end
      if (decim) begin
         next_s.d1     = s.i3;
         next_s.d2     = c1;
         next_s.d3     = c2;
         next_s.valid  = 1'b1;
         next_s.sample = sdcc_pkg::osr_scale(c3, osr_code);
      end
      if (!enable) begin
         next_s = '0;
      end
   end

   // State register.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign out_valid  = s.valid;
   assign out_sample = s.sample;

endmodule : sdcc_sinc3

// ===== logic/sdcc_channel_ctrl.sv
// Purpose: Decoder 0 control, shared ratio select and channel 4/5 buffer-full flags.
// Assumes: awprot[0]/arprot[0] high marks the supervisory core, low the processing core.
// Notes:   Modulator pins are asynchronous and pass a three-stage synchroniser.
//
// The register offsets and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/10ps

// What this block does
// - New channel-5 sample sets its buffer-full flag.
// - Flag, pair enable and masks raise interrupt.
// - Reading channel-5 sample clears its flag.
// - Two-bit code picks ratio 32 to 256.
// - Ratio writable only with all decoders off.
// - Decoder-0 enable bit switches decoder and filters.
// - Pin select bit picks single-ended or differential.
// - Only supervisory core writes decoder-0 enable.
// - Channel 4 and 5 flags set together.
// - Every reset clears the whole control register.
// - Core-select bit routes interrupts and clear rights.
module sdcc_channel_ctrl #(
   parameter int unsigned HALF_DIV = 5
) (
   // Clock and reset.
   input  wire logic                    aclk,
   input  wire logic                    aresetn,
   // Register bus.
   input  wire sdcc_pkg::sdcc_axil_req_t axi_req,
   output sdcc_pkg::sdcc_axil_rsp_t      axi_rsp,
   // Modulator bitstream pins.
   input  wire logic                    mod_line_p,
   input  wire logic                    mod_line_n,
   // Port and system status on the same clock.
   input  wire logic                    pin_output_select_bit,
   input  wire logic                    other_decoders_active,
   // Interrupts, one per core.
   output logic                         irq_supervisory,
   output logic                         irq_processing,
   // Front-end control.
   output logic                         decoder0_filters_on,
   output logic                         input_diff_mode
);
   localparam logic [7:0] DIV_LAST = 8'(HALF_DIV - 1);

   // Refuse dividers that the 8-bit counter cannot hold.
   initial begin
      if (HALF_DIV < 2 || HALF_DIV > 256) begin
         $error("sdcc_channel_ctrl: HALF_DIV must lie in 2..256");
      end
   end

   typedef struct packed {
      sdcc_pkg::sdcc_axil_rsp_t rsp;
      logic                  aw_held;
      logic [7:0]            aw_addr;
      logic                  aw_sup;
      logic                  w_held;
      logic [31:0]           wdata;
      logic [3:0]            wstrb;
      logic                  flag4;
      logic                  flag5;
      logic [1:0]            oversample_ratio_select;
      logic                  decoder0_enable;
      logic                  chan_pair_b_irq_enable;
      logic                  irq_core_route_select;
      logic [15:0]           sample4;
      logic [15:0]           sample5;
      logic [2:0]            status;
      logic [2:0]            mask;
      logic [2:0]            p_sync;
      logic [2:0]            n_sync;
      logic                  p_stable;
      logic                  n_stable;
      logic [7:0]            div_cnt;
      logic                  half_tick;
      logic                  have_first;
      logic                  first_half;
      logic                  pair_sel;
      logic                  bit_even;
      logic                  pair_valid;
      logic                  pair_bit_even;
      logic                  pair_bit_odd;
      logic [7:0]            pair_cnt;
      logic                  decim;
      logic                  irq_sup;
      logic                  irq_proc;
      logic                  filt_on;
      logic                  diff_mode;
   } sdcc_state_t;

   sdcc_state_t s;
   sdcc_state_t next_s;

   logic        f4_valid;
   logic [15:0] f4_sample;
   logic        f5_valid;
   logic [15:0] f5_sample;

   // Readable control image; unlisted bits read zero.
   function automatic logic [15:0] ctrl_image(input sdcc_state_t st);
      logic [15:0] v;
      v                         = sdcc_pkg::CTRL_RESET;
      v[sdcc_pkg::BIT_FLAG4]    = st.flag4;
      v[sdcc_pkg::BIT_FLAG5]    = st.flag5;
      v[sdcc_pkg::OSR_LSB +: 2] = st.oversample_ratio_select;
      v[sdcc_pkg::BIT_DEC0_EN]  = st.decoder0_enable;
      v[sdcc_pkg::BIT_IRQ_EN]   = st.chan_pair_b_irq_enable;
      v[sdcc_pkg::BIT_ROUTE]    = st.irq_core_route_select;
      return v;
   endfunction : ctrl_image

   // True when the accessing core owns the flags.
   function automatic logic may_clear(input logic is_sup, input logic route);
      return is_sup ? !route : route;
   endfunction : may_clear

   // Both channel filters share one decimation strobe, so their outputs align.
   sdcc_sinc3 u_filt4 (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .enable     (s.decoder0_enable),
      .osr_code   (s.oversample_ratio_select),
      .in_valid   (s.pair_valid),
      .in_bit     (s.pair_bit_even),
      .decim      (s.decim),
      .out_valid  (f4_valid),
      .out_sample (f4_sample)
   );

   sdcc_sinc3 u_filt5 (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .enable     (s.decoder0_enable),
      .osr_code   (s.oversample_ratio_select),
      .in_valid   (s.pair_valid),
      .in_bit     (s.pair_bit_odd),
      .decim      (s.decim),
      .out_valid  (f5_valid),
      .out_sample (f5_sample)
   );

   // Bus first, then hardware events, so a set beats a same-cycle clear.
   always_comb begin
      logic        line;
      logic        decoded;
      logic        is_sup;
      logic [15:0] img;
      line    = 1'b0;
      decoded = 1'b0;
      is_sup  = 1'b0;
      img     = ctrl_image(s);
      next_s  = s;
      next_s.pair_valid = 1'b0;
      next_s.decim      = 1'b0;
      next_s.half_tick  = 1'b0;

      // Address and data are taken in either order.
      if (s.rsp.awready && axi_req.awvalid) begin
         next_s.aw_held = 1'b1;
         next_s.aw_addr = axi_req.awaddr;
         next_s.aw_sup  = axi_req.awprot[0];
      end
      if (s.rsp.wready && axi_req.wvalid) begin
         next_s.w_held = 1'b1;
         next_s.wdata  = axi_req.wdata;
         next_s.wstrb  = axi_req.wstrb;
      end
      if (s.rsp.bvalid && axi_req.bready) begin
         next_s.rsp.bvalid = 1'b0;
      end
      if (s.aw_held && s.w_held && !s.rsp.bvalid) begin
         next_s.aw_held    = 1'b0;
         next_s.w_held     = 1'b0;
         next_s.rsp.bvalid = 1'b1;
         next_s.rsp.bresp  = sdcc_pkg::RESP_OKAY;
         unique case (s.aw_addr)
            sdcc_pkg::ADDR_CTRL: begin
               if (s.aw_sup) begin
                  if (s.wstrb[0] && !s.decoder0_enable && !other_decoders_active) begin
                     next_s.oversample_ratio_select = s.wdata[sdcc_pkg::OSR_LSB +: 2];
                  end
                  if (s.wstrb[1]) begin
                     next_s.decoder0_enable        = s.wdata[sdcc_pkg::BIT_DEC0_EN];
                     next_s.chan_pair_b_irq_enable = s.wdata[sdcc_pkg::BIT_IRQ_EN];
                     next_s.irq_core_route_select  = s.wdata[sdcc_pkg::BIT_ROUTE];
                  end
               end
            end
            sdcc_pkg::ADDR_SAMPLE4, sdcc_pkg::ADDR_SAMPLE5: begin
            end
            sdcc_pkg::ADDR_STATUS: begin
               if (s.wstrb[0] && may_clear(s.aw_sup, s.irq_core_route_select)) begin
                  next_s.status = s.status & ~s.wdata[sdcc_pkg::IRQ_W-1:0];
               end
            end
            sdcc_pkg::ADDR_MASK: begin
               if (s.wstrb[0]) begin
                  next_s.mask = s.wdata[sdcc_pkg::IRQ_W-1:0];
               end
            end
            default: begin
               next_s.rsp.bresp = sdcc_pkg::RESP_SLVERR;
            end
         endcase
      end
      next_s.rsp.awready = !next_s.aw_held;
      next_s.rsp.wready  = !next_s.w_held;

      // Reads answer a cycle after the take; sample reads clear flags.
      if (s.rsp.rvalid && axi_req.rready) begin
         next_s.rsp.rvalid = 1'b0;
      end
      if (s.rsp.arready && axi_req.arvalid) begin
         is_sup            = axi_req.arprot[0];
         next_s.rsp.rvalid = 1'b1;
         next_s.rsp.rresp  = sdcc_pkg::RESP_OKAY;
         next_s.rsp.rdata  = 32'h0000_0000;
         unique case (axi_req.araddr)
            sdcc_pkg::ADDR_CTRL: begin
               next_s.rsp.rdata[15:0] = img;
            end
            sdcc_pkg::ADDR_SAMPLE4: begin
               next_s.rsp.rdata[15:0] = s.sample4;
               if (may_clear(is_sup, s.irq_core_route_select)) begin
                  next_s.flag4 = 1'b0;
               end
            end
            sdcc_pkg::ADDR_SAMPLE5: begin
               next_s.rsp.rdata[15:0] = s.sample5;
               if (may_clear(is_sup, s.irq_core_route_select)) begin
                  next_s.flag5 = 1'b0;
               end
            end
            sdcc_pkg::ADDR_STATUS: begin
               next_s.rsp.rdata[sdcc_pkg::IRQ_W-1:0] = s.status;
            end
            sdcc_pkg::ADDR_MASK: begin
               next_s.rsp.rdata[sdcc_pkg::IRQ_W-1:0] = s.mask;
            end
            default: begin
               next_s.rsp.rresp = sdcc_pkg::RESP_SLVERR;
            end
         endcase
      end
      next_s.rsp.arready = !next_s.rsp.rvalid;

      // Three-stage synchroniser; only agreeing later stages move the stable level.
      next_s.p_sync = {s.p_sync[1:0], mod_line_p};
      next_s.n_sync = {s.n_sync[1:0], mod_line_n};
      if (s.p_sync[1] == s.p_sync[2]) begin
         next_s.p_stable = s.p_sync[2];
      end
      if (s.n_sync[1] == s.n_sync[2]) begin
         next_s.n_stable = s.n_sync[2];
      end

      // Differential mode wants the positive line above the negative one.
      line = s.diff_mode ? (s.p_stable & ~s.n_stable) : s.p_stable;

      // Half-bit divider and Manchester pairing; a missing mid-bit edge slips one half.
      if (s.div_cnt == DIV_LAST) begin
         next_s.div_cnt   = 8'h00;
         next_s.half_tick = 1'b1;
      end else begin
         next_s.div_cnt = s.div_cnt + 8'h01;
      end
      if (s.half_tick) begin
         if (!s.have_first) begin
            next_s.have_first = 1'b1;
            next_s.first_half = line;
         end else if (line != s.first_half) begin
            decoded           = s.first_half;
            next_s.have_first = 1'b0;
            if (!s.pair_sel) begin
               next_s.bit_even = decoded;
               next_s.pair_sel = 1'b1;
            end else begin
               next_s.pair_sel      = 1'b0;
               next_s.pair_valid    = 1'b1;
               next_s.pair_bit_even = s.bit_even;
               next_s.pair_bit_odd  = decoded;
            end
         end else begin
            next_s.first_half = line;
            next_s.status[sdcc_pkg::IRQ_SLIP] = 1'b1;
         end
      end

      // The shared ratio sets how many bit pairs make one output sample.
      if (s.pair_valid) begin
         if (s.pair_cnt == sdcc_pkg::osr_last(s.oversample_ratio_select)) begin
            next_s.pair_cnt = 8'h00;
            next_s.decim    = 1'b1;
         end else begin
            next_s.pair_cnt = s.pair_cnt + 8'h01;
         end
      end

      // A disabled decoder idles so a restart begins clean.
      if (!s.decoder0_enable) begin
         next_s.div_cnt    = 8'h00;
         next_s.half_tick  = 1'b0;
         next_s.have_first = 1'b0;
         next_s.pair_sel   = 1'b0;
         next_s.pair_valid = 1'b0;
         next_s.pair_cnt   = 8'h00;
         next_s.decim      = 1'b0;
      end

      // Both filters deliver in one cycle, so both flags rise together.
      if (f4_valid) begin
         next_s.flag4                     = 1'b1;
         next_s.sample4                   = f4_sample;
         next_s.status[sdcc_pkg::IRQ_CH4] = 1'b1;
      end
      if (f5_valid) begin
         next_s.flag5                     = 1'b1;
         next_s.sample5                   = f5_sample;
         next_s.status[sdcc_pkg::IRQ_CH5] = 1'b1;
      end

      // Only the owning core is interrupted, one cycle after status.
      next_s.irq_sup  = s.chan_pair_b_irq_enable && |(s.status & s.mask)
                        && !s.irq_core_route_select;
      next_s.irq_proc = s.chan_pair_b_irq_enable && |(s.status & s.mask)
                        && s.irq_core_route_select;
      next_s.filt_on   = s.decoder0_enable;
      next_s.diff_mode = s.decoder0_enable && pin_output_select_bit;
   end

   // State register; every reset clears all of it, the control register included.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   // Outputs come straight from state flip-flops.
   assign axi_rsp             = s.rsp;
   assign irq_supervisory     = s.irq_sup;
   assign irq_processing      = s.irq_proc;
   assign decoder0_filters_on = s.filt_on;
   assign input_diff_mode     = s.diff_mode;

endmodule : sdcc_channel_ctrl

// ===== sim/sdcc_channel_ctrl_sva.sv
// Purpose: Port checks for the channel control block.
// Assumes: The master offers address and data together.
// Notes:   Bound onto every instance of the block.
`timescale 1ns/10ps
module sdcc_channel_ctrl_sva #(
   parameter int unsigned HALF_DIV = 5
) (
   // Clock and reset.
   input wire logic                     aclk,
   input wire logic                     aresetn,
   // Register bus.
   input wire sdcc_pkg::sdcc_axil_req_t axi_req,
   input wire sdcc_pkg::sdcc_axil_rsp_t axi_rsp,
   // Pin select and outputs.
   input wire logic                     pin_output_select_bit,
   input wire logic                     irq_supervisory,
   input wire logic                     irq_processing,
   input wire logic                     decoder0_filters_on,
   input wire logic                     input_diff_mode
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Same-edge takes only.
   logic wt;
   logic rt;
   assign wt = axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
   assign rt = axi_req.arvalid && axi_rsp.arready;
   reset_clear_a: assert property (disable iff (1'b0)
      !aresetn |=> !decoder0_filters_on && !input_diff_mode && !irq_supervisory && !irq_processing)
      else $error("reset left outputs");
   diff_mode_a: assert property (
      input_diff_mode == (decoder0_filters_on && $past(pin_output_select_bit)))
      else $error("wrong input mode");
   irq_route_a: assert property (!(irq_supervisory && irq_processing))
      else $error("both cores interrupted");
   proc_enable_a: assert property (
      wt && axi_req.awaddr == sdcc_pkg::ADDR_CTRL && !axi_req.awprot[0]
      |=> $stable(decoder0_filters_on) [*4])
      else $error("processing core wrote enable");
   enable_write_a: assert property (
      $rose(decoder0_filters_on) |-> $past(axi_rsp.bvalid))
      else $error("enable without write");
   write_answer_a: assert property (wt |-> ##1 !axi_rsp.bvalid ##1 axi_rsp.bvalid)
      else $error("write answer timing");
   read_answer_a: assert property (rt |=> axi_rsp.rvalid)
      else $error("read answer late");
   b_holds_a: assert property (axi_rsp.bvalid && !axi_req.bready
      |=> axi_rsp.bvalid && $stable(axi_rsp.bresp))
      else $error("write answer dropped");
   r_holds_a: assert property (axi_rsp.rvalid && !axi_req.rready
      |=> axi_rsp.rvalid && $stable(axi_rsp.rdata))
      else $error("read answer dropped");
   unmapped_read_a: assert property (rt && axi_req.araddr == 8'h00
      |=> axi_rsp.rresp == sdcc_pkg::RESP_SLVERR && axi_rsp.rdata == 32'h0)
      else $error("unmapped read not refused");
   // Main scenarios.
   cover property (wt);
   cover property ($rose(irq_supervisory));
   cover property ($rose(irq_processing));
endmodule : sdcc_channel_ctrl_sva

bind sdcc_channel_ctrl sdcc_channel_ctrl_sva #(.HALF_DIV(HALF_DIV)) sdcc_channel_ctrl_sva_i (
   .aclk(aclk), .aresetn(aresetn), .axi_req(axi_req), .axi_rsp(axi_rsp),
   .pin_output_select_bit(pin_output_select_bit), .irq_supervisory(irq_supervisory),
   .irq_processing(irq_processing), .decoder0_filters_on(decoder0_filters_on),
   .input_diff_mode(input_diff_mode));

// ===== sim/sdcc_mod_source.sv
// Purpose: Behavioural modulator sending a Manchester bitstream.
// Assumes: A bit is its level in the first half, the inverse after.
// Notes:   The negative line is the inverse, so both input modes work.
`timescale 1ns/10ps
module sdcc_mod_source #(
   parameter int unsigned HALF_DIV = 2
) (
   // Clock and control.
   input wire logic aclk,
   input wire logic run,
   // Modulator lines.
   output logic     mod_line_p,
   output logic     mod_line_n
);
   logic [7:0] pattern;
   logic       second;
   int         tick;
   // Known start level.
   initial begin
      pattern = 8'hB4;
      second = 1'b0;
      tick = 0;
      mod_line_p = 1'b0;
      mod_line_n = 1'b1;
   end
   // A stopped modulator holds its lines still.
   always @(posedge aclk) begin
      if (run) begin
         mod_line_p <= pattern[7] ^ second;
         mod_line_n <= ~(pattern[7] ^ second);
         tick <= (tick == HALF_DIV - 1) ? 0 : tick + 1;
         if (tick == HALF_DIV - 1) begin
            second <= ~second;
            if (second) pattern <= {pattern[6:0], pattern[7]};
         end
      end
   end
endmodule : sdcc_mod_source

// ===== sim/testbench.sv
// Purpose: Self-checking bench for the channel control block.
// Assumes: HALF_DIV of 2 gives a sample about every 256 clocks.
// Notes:   Sample values are not compared; the decoder lock phase is free.
`timescale 1ns/10ps
module testbench;
   localparam logic [7:0] A_CTRL = sdcc_pkg::ADDR_CTRL;
   localparam logic [7:0] A_S5   = sdcc_pkg::ADDR_SAMPLE5;
   localparam logic [7:0] A_STAT = sdcc_pkg::ADDR_STATUS;
   localparam logic [7:0] A_MASK = sdcc_pkg::ADDR_MASK;
   localparam logic [1:0] OK     = sdcc_pkg::RESP_OKAY;
   logic                     aclk    = 1'b0;
   logic                     aresetn = 1'b0;
   sdcc_pkg::sdcc_axil_req_t req     = '0;
   sdcc_pkg::sdcc_axil_rsp_t rsp;
   logic                     run     = 1'b0;
   logic                     pin_sel = 1'b0;
   logic                     others  = 1'b0;
   logic                     mod_p, mod_n, irq_s, irq_p, filt_on, diff;
   logic [31:0]              rd;
   logic [1:0]               resp;
   int                       failures    = 0;
   int                       comparisons = 0;
   // Free-running clock.
   initial begin
      forever #5 aclk = ~aclk;
   end
   sdcc_channel_ctrl #(.HALF_DIV(2)) sdcc_channel_ctrl_i (
      .aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp),
      .mod_line_p(mod_p), .mod_line_n(mod_n), .pin_output_select_bit(pin_sel),
      .other_decoders_active(others), .irq_supervisory(irq_s), .irq_processing(irq_p),
      .decoder0_filters_on(filt_on), .input_diff_mode(diff));
   sdcc_mod_source #(.HALF_DIV(2)) sdcc_mod_source_i (
      .aclk(aclk), .run(run), .mod_line_p(mod_p), .mod_line_n(mod_n));
   // Counts and reports one comparison.
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : check
   // Counts line, verdict, stop.
   task automatic end_sim();
      $display("comparisons %0d, failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : end_sim
   // Write; bready comes late so the held answer gets exercised.
   task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic p,
                     input logic [1:0] er);
      int n;
      n = 0;
      req.awvalid <= 1'b1;
      req.awaddr <= a;
      req.awprot <= {2'h0, p};
      req.wvalid <= 1'b1;
      req.wdata <= {16'h0000, d};
      req.wstrb <= 4'hF;
      do begin
         @(posedge aclk);
         if (rsp.awready) req.awvalid <= 1'b0;
         if (rsp.wready) req.wvalid <= 1'b0;
         req.bready <= (n > 1) && !(rsp.bvalid && req.bready);
         n++;
      end while (!(rsp.bvalid && req.bready));
      check({30'h0, rsp.bresp}, {30'h0, er});
   endtask : wr
   // Read into rd and resp, with rready also late.
   task automatic rdr(input logic [7:0] a, input logic p);
      int n;
      n = 0;
      req.arvalid <= 1'b1;
      req.araddr <= a;
      req.arprot <= {2'h0, p};
      do begin
         @(posedge aclk);
         if (rsp.arready) req.arvalid <= 1'b0;
         req.rready <= (n > 0) && !(rsp.rvalid && req.rready);
         n++;
      end while (!(rsp.rvalid && req.rready));
      rd = rsp.rdata;
      resp = rsp.rresp;
   endtask : rdr
   task automatic rc(input logic [7:0] a, input logic [31:0] exp);
      rdr(a, 1'b1);
      check(rd, exp);
   endtask : rc
   // Bounded interrupt wait.
   task automatic wait_irq(input logic which);
      int n;
      n = 0;
      while (!(which ? irq_p : irq_s) && n < 1500) begin
         @(posedge aclk);
         n++;
      end
      check({31'h0, which ? irq_p : irq_s}, 32'h1);
   endtask : wait_irq
   // Watchdog.
   initial begin
      repeat (20000) @(posedge aclk);
      failures++;
      end_sim();
   end
   // Test sequence.
   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      rc(A_CTRL, 32'h0);
      rc(A_MASK, 32'h0);
      rdr(8'h00, 1'b1);
      check({30'h0, resp}, {30'h0, sdcc_pkg::RESP_SLVERR});
      wr(8'h00, 16'hFFFF, 1'b1, sdcc_pkg::RESP_SLVERR);
      $display("test reset_map done");
      for (int c = 0; c < 4; c++) begin
         wr(A_CTRL, 16'(c << 6), 1'b1, OK);
         rc(A_CTRL, 32'(c << 6));
      end
      wr(A_CTRL, 16'h0100, 1'b0, OK);
      rc(A_CTRL, 32'h00C0);
      others <= 1'b1;
      wr(A_CTRL, 16'h0000, 1'b1, OK);
      rc(A_CTRL, 32'h00C0);
      others <= 1'b0;
      wr(A_CTRL, 16'h0100, 1'b1, OK);
      check({31'h0, filt_on}, 32'h1);
      wr(A_CTRL, 16'h41C0, 1'b1, OK);
      rc(A_CTRL, 32'h4100);
      $display("test control done");
      pin_sel <= 1'b1;
      repeat (2) @(posedge aclk);
      check({31'h0, diff}, 32'h1);
      wr(A_MASK, 16'h0003, 1'b1, OK);
      run <= 1'b1;
      wait_irq(1'b0);
      rc(A_CTRL, 32'h4130);
      check({31'h0, irq_p}, 32'h0);
      rdr(A_S5, 1'b1);
      rc(A_CTRL, 32'h4110);
      wr(A_MASK, 16'h0000, 1'b1, OK);
      check({31'h0, irq_s}, 32'h0);
      wr(A_STAT, 16'h0007, 1'b1, OK);
      rdr(A_STAT, 1'b1);
      check(rd & 32'h3, 32'h0);
      $display("test stream done");
      wr(A_CTRL, 16'hC100, 1'b1, OK);
      wr(A_MASK, 16'h0003, 1'b1, OK);
      wait_irq(1'b1);
      wr(A_STAT, 16'h0003, 1'b1, OK);
      check({31'h0, irq_p}, 32'h1);
      run <= 1'b0;
      wr(A_CTRL, 16'h0000, 1'b1, OK);
      check({31'h0, filt_on}, 32'h0);
      $display("test routing done");
      end_sim();
   end
endmodule : testbench
